// >>> logic/ppo_output_ctrl.sv
// How it works
// RULE_01: Normal counter: off below target, else on
// RULE_02: Inverted counter: on below target, else off
// RULE_03: Reset command or button clears count
// RULE_04: Pulse source stays at or below 0.1 Hz
// RULE_05: Function 6 counts pulses, inputs 1-5
// RULE_06: Heating action: on raises process value
// RULE_07: Error is target minus process value
// RULE_08: Regulator runs once per control period
// RULE_09: Output on for power share of cycle
// RULE_10: Span is target times percent over 100
// RULE_11: Rate is current minus previous value
// RULE_12: Error sum grows by error each run
// RULE_13: Power formula with gains over span
// RULE_14: Power clamped between zero and hundred
// RULE_15: Power capped by maximum setting 10-100
// RULE_16: Cap only after error below 3/4 span
// RULE_17: Function code and input select fields
// RULE_18: Pulse counter saturates, never wraps
// RULE_19: Start clears sum, loads previous value
`timescale 1ns/1ps
`include "ppo_params.svh"

module ppo_output_ctrl #(
    parameter int PV_W = 16,
    parameter int CNT_W = 16,
    parameter longint SEC_CYCLES = `PPO_SEC_CYCLES,
    parameter longint CENTI_CYCLES = `PPO_CENTI_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [`PPO_NUM_CHAN-1:0] pulse_in,
    input wire logic reset_button,
    input wire logic [`PPO_NUM_CHAN*PV_W-1:0] chan_values,
    output logic relay_out
);
    import ppo_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (PV_W < 12 || PV_W > 24) begin : g_bad_pv
            $error("PV_W must be 12 to 24");
        end
        if (CNT_W < 12 || CNT_W > 31) begin : g_bad_cnt
            $error("CNT_W must be 12 to 31");
        end
        if (SEC_CYCLES < 2 || CENTI_CYCLES < 1 || SEC_CYCLES > 64'hFFFFFFFF) begin : g_bad_t
            $error("tick counts out of range");
        end
    endgenerate

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic rst_q1;
    logic rst_n;
    logic [`PPO_NUM_CHAN-1:0] pulse_s;
    logic [`PPO_NUM_CHAN-1:0] pulse_prev;
    logic button_s;
    logic button_prev;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    ppo_sync #(.W(`PPO_NUM_CHAN + 1)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .d({reset_button, pulse_in}),
        .q({button_s, pulse_s})
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_prev <= '0;
            button_prev <= 1'b0;
        end else if (ce) begin
            pulse_prev <= pulse_s;
            button_prev <= button_s;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    ppo_func_t func;
    logic [2:0] chan;
    logic [15:0] target;
    logic invert;
    logic [15:0] prop;
    logic [15:0] der;
    logic [15:0] integ;
    logic [6:0] max_pwr;
    logic [7:0] ctrl_period;
    logic [7:0] mod_period;
    logic func_wr;
    logic clr_cmd;

    assign func_wr = reg_wr && reg_addr == `PPO_REG_FUNC;
    assign clr_cmd = reg_wr && reg_addr == `PPO_REG_CMD && reg_wdata[`PPO_CMD_CLR_COUNT_BIT];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            func <= PPO_FN_OFF;
            chan <= `PPO_RST_CHAN;
            target <= `PPO_RST_TARGET;
            invert <= 1'b0;
            prop <= `PPO_RST_PROP;
            der <= `PPO_RST_DER;
            integ <= `PPO_RST_INT;
            max_pwr <= `PPO_RST_MAXPWR;
            ctrl_period <= `PPO_RST_CTRL_PERIOD;
            mod_period <= `PPO_RST_MOD_PERIOD;
        end else if (ce && reg_wr) begin
            unique case (reg_addr)
                `PPO_REG_FUNC: func <= ppo_func_t'(reg_wdata[2:0]); // RULE_17
                `PPO_REG_CHAN: begin
                    if (reg_wdata[2:0] >= 3'h1 && reg_wdata[2:0] <= 3'h5) begin // RULE_05
                        chan <= reg_wdata[2:0]; // RULE_17
                    end
                end
                `PPO_REG_TARGET: target <= reg_wdata[15:0];
                `PPO_REG_INVERT: invert <= reg_wdata[0];
                `PPO_REG_PROP: prop <= reg_wdata[15:0];
                `PPO_REG_DER: der <= reg_wdata[15:0];
                `PPO_REG_INT: integ <= reg_wdata[15:0];
                `PPO_REG_MAXPWR: begin
                    if (reg_wdata[6:0] < `PPO_PWR_MIN) begin // RULE_15
                        max_pwr <= `PPO_PWR_MIN;
                    end else if (reg_wdata[6:0] > `PPO_PWR_FULL || reg_wdata[31:7] != '0) begin
                        max_pwr <= `PPO_PWR_FULL;
                    end else begin
                        max_pwr <= reg_wdata[6:0];
                    end
                end
                `PPO_REG_CTRL_PERIOD: begin
                    ctrl_period <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
                end
                `PPO_REG_MOD_PERIOD: begin
                    mod_period <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pulse counter
    // ------------------------------------------------------------
    logic [CNT_W-1:0] count;
    logic pulse_edge;
    logic button_edge;
    logic [CNT_W-1:0] target_cnt;
    logic cnt_reached;

    assign pulse_edge = pulse_s[chan - 3'h1] && !pulse_prev[chan - 3'h1]; // RULE_05 RULE_04
    assign button_edge = button_s && !button_prev;
    assign target_cnt = CNT_W'(target[10:0]);
    assign cnt_reached = count >= target_cnt;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (ce) begin
            if (clr_cmd || button_edge) begin
                count <= '0; // RULE_03
            end else if (func == PPO_FN_COUNT && pulse_edge && count != '1) begin
                count <= count + CNT_W'(1); // RULE_18
            end
        end
    end

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    logic [31:0] sec_div;
    logic [31:0] centi_div;
    logic sec_tick;
    logic centi_tick;
    logic [7:0] ctrl_sec;
    logic exec;

    assign sec_tick = sec_div == 32'(SEC_CYCLES - 1);
    assign centi_tick = centi_div == 32'(CENTI_CYCLES - 1);
    assign exec = sec_tick && ctrl_sec >= ctrl_period - 8'h01 && func == PPO_FN_PID;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sec_div <= '0;
            centi_div <= '0;
            ctrl_sec <= '0;
        end else if (ce) begin
            sec_div <= sec_tick ? '0 : sec_div + 32'h1;
            centi_div <= centi_tick ? '0 : centi_div + 32'h1;
            if (func_wr) begin
                ctrl_sec <= '0;
            end else if (sec_tick) begin
                ctrl_sec <= (ctrl_sec >= ctrl_period - 8'h01) ? 8'h00 : ctrl_sec + 8'h01; // RULE_08
            end
        end
    end

    // ------------------------------------------------------------
    // Regulator arithmetic
    // ------------------------------------------------------------
    logic signed [PV_W-1:0] pv;
    logic signed [PV_W-1:0] prev_pv;
    logic signed [31:0] err_sum;
    logic signed [31:0] err;
    logic signed [31:0] rate;
    logic signed [31:0] span;
    logic signed [63:0] numer;
    logic signed [63:0] raw_pwr;
    logic [6:0] clamped;
    logic [6:0] power;
    logic regulating;
    logic near_target;

    assign pv = chan_values[(chan - 3'h1) * PV_W +: PV_W]; // RULE_17
    assign err = 32'(signed'(target)) - 32'(pv); // RULE_07 RULE_06
    assign rate = 32'(pv) - 32'(prev_pv); // RULE_11
    assign span = 32'((64'(signed'(target)) * 64'(signed'({1'b0, prop}))) / 64'sd100); // RULE_10
    // Scaled by 1000 to keep gain fractions exact
    assign numer = 64'sd1000 * 64'(err) - 64'sd100 * 64'(der) * 64'(rate)
        + 64'(integ) * 64'(err_sum); // RULE_13
    assign near_target = 64'sd4 * 64'(err) < 64'sd3 * 64'(span); // RULE_16

    always_comb begin
        if (span <= 32'sd0) begin
            raw_pwr = (numer > 64'sd0) ? 64'sd100 : 64'sd0;
        end else begin
            raw_pwr = numer / (64'sd10 * 64'(span)); // RULE_13
        end
        if (raw_pwr < 64'sd0) begin
            clamped = 7'h00; // RULE_14
        end else if (raw_pwr > 64'(`PPO_PWR_FULL)) begin
            clamped = `PPO_PWR_FULL; // RULE_14
        end else begin
            clamped = raw_pwr[6:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev_pv <= '0;
            err_sum <= '0;
            power <= '0;
            regulating <= 1'b0;
        end else if (ce) begin
            if (func_wr) begin
                prev_pv <= pv; // RULE_19
                err_sum <= '0; // RULE_19
                power <= '0;
                regulating <= 1'b0;
            end else if (exec) begin
                prev_pv <= pv;
                err_sum <= err_sum + err; // RULE_12
                if (regulating || near_target) begin
                    regulating <= 1'b1; // RULE_16
                    power <= (clamped > max_pwr) ? max_pwr : clamped; // RULE_15
                end else begin
                    power <= clamped;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Modulation cycle
    // ------------------------------------------------------------
    logic [15:0] phase;
    logic [15:0] cycle_len;
    logic [15:0] on_len;

    assign cycle_len = 16'(mod_period * 8'd100);
    assign on_len = 16'(power * mod_period);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= '0;
        end else if (ce) begin
            if (func_wr) begin
                phase <= '0;
            end else if (centi_tick) begin
                phase <= (phase >= cycle_len - 16'h1) ? 16'h0 : phase + 16'h1; // RULE_09
            end
        end
    end

    // ------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            relay_out <= 1'b0;
        end else if (ce) begin
            unique case (func)
                PPO_FN_COUNT: relay_out <= invert ? !cnt_reached : cnt_reached; // RULE_01 RULE_02
                PPO_FN_PID: relay_out <= phase < on_len; // RULE_09
                default: relay_out <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    `PPO_REG_FUNC: reg_rdata <= 32'(func);
                    `PPO_REG_CHAN: reg_rdata <= 32'(chan);
                    `PPO_REG_TARGET: reg_rdata <= 32'(target);
                    `PPO_REG_INVERT: reg_rdata <= 32'(invert);
                    `PPO_REG_PROP: reg_rdata <= 32'(prop);
                    `PPO_REG_DER: reg_rdata <= 32'(der);
                    `PPO_REG_INT: reg_rdata <= 32'(integ);
                    `PPO_REG_MAXPWR: reg_rdata <= 32'(max_pwr);
                    `PPO_REG_CTRL_PERIOD: reg_rdata <= 32'(ctrl_period);
                    `PPO_REG_MOD_PERIOD: reg_rdata <= 32'(mod_period);
                    `PPO_REG_COUNT: reg_rdata <= 32'(count);
                    `PPO_REG_POWER: reg_rdata <= 32'(power);
                    `PPO_REG_STATE: reg_rdata <= {30'h0, regulating, relay_out};
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

endmodule : ppo_output_ctrl

// >>> logic/ppo_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser for pin-level inputs
module ppo_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : ppo_sync

// >>> pkg/ppo_params.svh
`ifndef PPO_PARAMS_SVH
`define PPO_PARAMS_SVH

// Register byte offsets
`define PPO_REG_FUNC        8'h00
`define PPO_REG_CHAN        8'h04
`define PPO_REG_TARGET      8'h08
`define PPO_REG_INVERT      8'h0C
`define PPO_REG_PROP        8'h10
`define PPO_REG_DER         8'h14
`define PPO_REG_INT         8'h18
`define PPO_REG_MAXPWR      8'h1C
`define PPO_REG_CTRL_PERIOD 8'h20
`define PPO_REG_MOD_PERIOD  8'h24
`define PPO_REG_CMD         8'h28
`define PPO_REG_COUNT       8'h2C
`define PPO_REG_POWER       8'h30
`define PPO_REG_STATE       8'h34

// Field positions
`define PPO_CMD_CLR_COUNT_BIT 0
`define PPO_STATE_OUT_BIT     0
`define PPO_STATE_REG_BIT     1

// Reset values
`define PPO_RST_CHAN        3'h1
`define PPO_RST_TARGET      16'h0000
`define PPO_RST_PROP        16'h000A
`define PPO_RST_DER         16'h0000
`define PPO_RST_INT         16'h0000
`define PPO_RST_MAXPWR      7'h64
`define PPO_RST_CTRL_PERIOD 8'h01
`define PPO_RST_MOD_PERIOD  8'h0A

// Limits
`define PPO_TARGET_MAX      16'h07FF
`define PPO_PWR_MIN         7'h0A
`define PPO_PWR_FULL        7'h64
`define PPO_NUM_CHAN        5

// Timing
`define PPO_CLK_PERIOD_PS   4000
`define PPO_SEC_PS          64'd1000000000000
`define PPO_CENTI_PS        64'd10000000000
`define PPO_SEC_CYCLES      (`PPO_SEC_PS / `PPO_CLK_PERIOD_PS)
`define PPO_CENTI_CYCLES    (`PPO_CENTI_PS / `PPO_CLK_PERIOD_PS)

`endif

// >>> pkg/ppo_pkg.sv
package ppo_pkg;

    typedef enum logic [2:0] {
        PPO_FN_OFF = 3'h0,
        PPO_FN_PID = 3'h5,
        PPO_FN_COUNT = 3'h6
    } ppo_func_t;

endpackage : ppo_pkg

// >>> test/ppo_output_ctrl_monitor.sv
`timescale 1ns/1ps
`include "ppo_params.svh"
module ppo_output_ctrl_monitor #(
    parameter int PV_W = 16,
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [`PPO_NUM_CHAN-1:0] pulse_in,
    input wire logic reset_button,
    input wire logic [`PPO_NUM_CHAN*PV_W-1:0] chan_values,
    input wire logic relay_out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    sequence clr_s;
        ce && reg_wr && reg_addr == `PPO_REG_CMD && reg_wdata[0];
    endsequence
    sequence rd_cnt_s;
        ce && reg_rd && reg_addr == `PPO_REG_COUNT;
    endsequence
    rdata_idle_a: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read");
    unmapped_rd_a: assert property (ce && reg_rd && reg_addr > 8'h34 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    count_clear_a: assert property (clr_s ##1 rd_cnt_s |=> reg_rdata == 32'h0)
        else $error("count not cleared");
    count_width_a: assert property (rd_cnt_s |=> (reg_rdata >> CNT_W) == 32'h0)
        else $error("count beyond width");
    power_range_a: assert property (ce && reg_rd && reg_addr == `PPO_REG_POWER
        |=> reg_rdata <= 32'd100)
        else $error("power above full");
    maxpwr_range_a: assert property (ce && reg_rd && reg_addr == `PPO_REG_MAXPWR
        |=> reg_rdata inside {[32'd10:32'd100]})
        else $error("power cap out of range");
    chan_range_a: assert property (ce && reg_rd && reg_addr == `PPO_REG_CHAN
        |=> reg_rdata inside {[32'd1:32'd5]})
        else $error("input select out of range");
    relay_freeze_a: assert property (!ce |=> $stable(relay_out) && $stable(reg_rdata))
        else $error("state moved with enable low");
endmodule : ppo_output_ctrl_monitor
bind ppo_output_ctrl ppo_output_ctrl_monitor #(.PV_W(PV_W), .CNT_W(CNT_W)) u_mon (
    .mclk(mclk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pulse_in(pulse_in),
    .reset_button(reset_button), .chan_values(chan_values), .relay_out(relay_out));

// >>> test/ppo_output_ctrl_test.sv
`timescale 1ns/1ps
module ppo_output_ctrl_test;
    logic mclk = 0, arst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, btn = 0, fire = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [2:0] sel = 3'h1;
    logic [15:0] pv = 16'h0000;
    logic [4:0] pulse_in;
    logic [79:0] chan_values;
    logic relay_out;
    int heat, h0, num_errors = 0, n_checks = 0;
    logic [7:0] ra [13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
        8'h1C, 8'h20, 8'h24, 8'h2C, 8'h30, 8'hFC};
    logic [31:0] rv [13] = '{0, 1, 0, 0, 10, 0, 0, 100, 1, 10, 0, 0, 0};
    initial forever #2 mclk = ~mclk;
    ppo_output_ctrl #(.CNT_W(12), .SEC_CYCLES(100), .CENTI_CYCLES(1)) u_ppo_output_ctrl (
        .mclk(mclk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pulse_in(pulse_in),
        .reset_button(btn), .chan_values(chan_values), .relay_out(relay_out));
    ppo_plant #(.PV_W(16)) u_ppo_plant (.mclk(mclk), .fire(fire), .sel(sel), .pv(pv),
        .relay_out(relay_out), .pulse_in(pulse_in), .chan_values(chan_values), .heat(heat));
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
        @(posedge mclk);
    endtask : rd
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [7:0] ra,
        input logic [31:0] e);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ra;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
        @(posedge mclk);
    endtask : wr_rd
    task automatic rl(input logic e);
        #1 chk({31'h0, relay_out}, {31'h0, e});
        @(posedge mclk);
    endtask : rl
    task automatic pulse(input logic [2:0] c);
        sel <= c;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        tick(7);
    endtask : pulse
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        tick(4);
        for (int i = 0; i < 13; i++) rd(ra[i], rv[i]);
        wr(8'h04, 6);
        rd(8'h04, 1);
        wr(8'h1C, 5);
        rd(8'h1C, 10);
        wr(8'h1C, 120);
        rd(8'h1C, 100);
        $display("test registers done");
        wr(8'h00, 6);
        wr(8'h04, 2);
        wr(8'h08, 3);
        pulse(1);
        rd(8'h2C, 0);
        pulse(2);
        pulse(2);
        rl(0);
        pulse(2);
        rd(8'h2C, 3);
        rl(1);
        wr(8'h0C, 1);
        tick(2);
        rl(0);
        rd(8'h34, 32'h0);
        ce <= 1'b0;
        tick(6);
        ce <= 1'b1;
        wr_rd(8'h28, 1, 8'h2C, 0);
        rl(1);
        repeat (4100) pulse(2);
        rd(8'h2C, 32'h0FFF);
        btn <= 1'b1;
        tick(4);
        btn <= 1'b0;
        tick(4);
        rd(8'h2C, 0);
        $display("test counter done");
        sel <= 3'h1;
        pv <= 16'd800;
        wr(8'h24, 1);
        wr(8'h08, 1000);
        wr(8'h04, 1);
        wr(8'h1C, 30);
        wr(8'h00, 5);
        tick(150);
        rd(8'h30, 100);
        pv <= 16'd950;
        tick(100);
        rd(8'h30, 30);
        h0 = heat;
        tick(100);
        chk(32'(heat - h0), 30);
        wr(8'h1C, 100);
        wr(8'h14, 10);
        wr(8'h00, 5);
        tick(50);
        pv <= 16'd940;
        tick(100);
        rd(8'h30, 70);
        wr(8'h14, 0);
        wr(8'h18, 100);
        wr(8'h20, 2);
        pv <= 16'd950;
        wr(8'h00, 5);
        tick(99);
        rd(8'h30, 0);
        tick(148);
        rd(8'h30, 50);
        tick(198);
        rd(8'h30, 55);
        tick(198);
        rd(8'h30, 60);
        $display("test regulator done");
        close_out();
    end
    initial begin
        tick(60000);
        num_errors++;
        close_out();
    end
endmodule : ppo_output_ctrl_test

// >>> test/ppo_plant.sv
`timescale 1ns/1ps
module ppo_plant #(
    parameter int PV_W = 16
) (
    input wire logic mclk,
    input wire logic fire,
    input wire logic [2:0] sel,
    input wire logic [PV_W-1:0] pv,
    input wire logic relay_out,
    output logic [4:0] pulse_in,
    output logic [5*PV_W-1:0] chan_values,
    output int heat
);
    int hold = 0;
    initial begin
        pulse_in = 5'h00;
        heat = 0;
    end
    // Pulse high 4 cycles; caller spaces pulses
    always @(posedge mclk) begin
        hold <= fire ? 4 : (hold > 0 ? hold - 1 : 0);
        pulse_in <= (hold > 0) ? (5'h01 << (sel - 3'h1)) : 5'h00;
    end
    // Energised cycles of the heater
    always @(posedge mclk) begin
        if (relay_out === 1'b1) heat <= heat + 1;
    end
    // Unselected inputs carry the inverse value
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            chan_values[k*PV_W +: PV_W] = (k == sel - 1) ? pv : ~pv;
        end
    end
endmodule : ppo_plant
